// File: dual_byte_timer_params.svh
`ifndef DUAL_BYTE_TIMER_PARAMS_SVH
`define DUAL_BYTE_TIMER_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define IDX_TIMER_CONTROL    16'hFE10
`define IDX_PRESCALER_MATCH  16'hFE11
`define IDX_LOW_COUNT        16'hFE12
`define IDX_HIGH_COUNT       16'hFE13
`define IDX_LOW_MATCH_VALUE  16'hFE14
`define IDX_HIGH_MATCH_VALUE 16'hFE15
`define IDX_LOW_CAPTURE_A    16'hFE16
`define IDX_HIGH_CAPTURE_A   16'hFE17
`define IDX_LOW_CAPTURE_B    16'hFE1E
`define IDX_HIGH_CAPTURE_B   16'hFE1F

// Control register field positions
`define CTL_HIGH_RUN_BIT       7
`define CTL_LOW_RUN_BIT        6
`define CTL_JOINED_BIT         5
`define CTL_LOW_EXT_BIT        4
`define CTL_HIGH_FLAG_BIT      3
`define CTL_HIGH_IE_BIT        2
`define CTL_LOW_FLAG_BIT       1
`define CTL_LOW_IE_BIT         0

// Reset values
`define RST_TIMER_CONTROL      8'h00
`define RST_PRESCALER_MATCH    8'h00
`define RST_COUNT              8'h00
`define RST_MATCH_VALUE        8'h00
`define RST_CAPTURE            8'h00

`endif

// File: dual_byte_timer_pkg.sv
package dual_byte_timer_pkg;

  typedef struct packed {
    logic high_run;
    logic low_run;
    logic joined_length_select;
    logic low_external_clock_select;
    logic high_match_flag;
    logic high_irq_enable;
    logic low_match_flag;
    logic low_irq_enable;
  } timer_control_t;

  // Single-cycle detection pulses from the external edge detectors
  typedef struct packed {
    logic low_capture_input;
    logic low_capture_input_b;
    logic high_capture_input;
    logic high_capture_input_b;
  } capture_pulses_t;

endpackage

// File: dual_byte_timer.sv
// Summary of operation
// - Dual byte mode: both bytes share prescaler
// - Byte period is (match+1) times (prescaler+1)
// - Low capture pulse copies low byte
// - Low capture b pulse copies low byte
// - High capture pulse copies high byte
// - High capture b pulse copies high byte
// - Mixed mode: low byte counts external events
// - Low event period is match plus one events
// - Joined timer mode: 16-bit prescaled timer
// - Joined period is (match16+1) times (prescaler+1)
// - Joined event mode counts external events
// - Joined: high capture copies both bytes
// - Joined: high capture b copies both
// - Interrupt per period when enabled
// - Bit 5 joins bytes, bit 4 selects events
// - Run bit clear holds counter at zero
// - Compare buffer reloads when stopped or matched
// - Match flag sticky, cleared by software write
`include "dual_byte_timer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dual_byte_timer
  import dual_byte_timer_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            event_count_input,
  input  wire capture_pulses_t capture_pulses,
  output logic                 prescaler_tick,
  output logic                 low_irq,
  output logic                 high_irq
);

  timer_control_t ctl_r;
  logic [7:0]     prescaler_match_r;
  logic [7:0]     low_match_value_r;
  logic [7:0]     high_match_value_r;
  logic [7:0]     pre_cnt_r;
  logic [7:0]     low_counter_r;
  logic [7:0]     high_counter_r;
  logic [7:0]     low_buf_r;
  logic [7:0]     high_buf_r;
  logic [7:0]     low_capture_a_r;
  logic [7:0]     high_capture_a_r;
  logic [7:0]     low_capture_b_r;
  logic [7:0]     high_capture_b_r;
  logic [31:0]    prdata_r;

  logic           setup;
  logic           wr;
  logic           hit_ctl;
  logic           hit_prr;
  logic           hit_low_cnt;
  logic           hit_high_cnt;
  logic           hit_lmv;
  logic           hit_hmv;
  logic           hit_lca;
  logic           hit_hca;
  logic           hit_lcb;
  logic           hit_hcb;
  logic           hit_any;
  logic           pre_match;
  logic           low_inc;
  logic           joined_run;
  logic           joined_match;
  logic           low_match;
  logic           high_match;
  logic           low_step;
  logic           high_step;
  logic           cap_la_ev;
  logic           cap_ha_ev;
  logic           cap_lb_ev;
  logic           cap_hb_ev;
  logic [7:0]     ctl_nxt;

  function automatic logic addr_hit(input logic [31:0] a, input logic [15:0] idx);
    addr_hit = (a[1:0] == 2'h0) && (a[31:2] == {14'h0000, idx});
  endfunction

  // APB decode; the slave never inserts wait states
  assign setup        = psel & ~penable;
  assign wr           = psel & penable & pwrite;
  assign hit_ctl      = addr_hit(paddr, `IDX_TIMER_CONTROL);
  assign hit_prr      = addr_hit(paddr, `IDX_PRESCALER_MATCH);
  assign hit_low_cnt  = addr_hit(paddr, `IDX_LOW_COUNT);
  assign hit_high_cnt = addr_hit(paddr, `IDX_HIGH_COUNT);
  assign hit_lmv      = addr_hit(paddr, `IDX_LOW_MATCH_VALUE);
  assign hit_hmv      = addr_hit(paddr, `IDX_HIGH_MATCH_VALUE);
  assign hit_lca      = addr_hit(paddr, `IDX_LOW_CAPTURE_A);
  assign hit_hca      = addr_hit(paddr, `IDX_HIGH_CAPTURE_A);
  assign hit_lcb      = addr_hit(paddr, `IDX_LOW_CAPTURE_B);
  assign hit_hcb      = addr_hit(paddr, `IDX_HIGH_CAPTURE_B);
  assign hit_any      = hit_ctl | hit_prr | hit_low_cnt | hit_high_cnt | hit_lmv | hit_hmv |
                        hit_lca | hit_hca | hit_lcb | hit_hcb;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_r;

  // Read data is sampled in the setup cycle so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_r <= 32'h00000000;
      if (hit_ctl) begin
        prdata_r[7:0] <= ctl_r;
      end else if (hit_prr) begin
        prdata_r[7:0] <= prescaler_match_r;
      end else if (hit_low_cnt) begin
        prdata_r[7:0] <= low_counter_r;
      end else if (hit_high_cnt) begin
        prdata_r[7:0] <= high_counter_r;
      end else if (hit_lmv) begin
        prdata_r[7:0] <= low_match_value_r;
      end else if (hit_hmv) begin
        prdata_r[7:0] <= high_match_value_r;
      end else if (hit_lca) begin
        prdata_r[7:0] <= low_capture_a_r;
      end else if (hit_hca) begin
        prdata_r[7:0] <= high_capture_a_r;
      end else if (hit_lcb) begin
        prdata_r[7:0] <= low_capture_b_r;
      end else if (hit_hcb) begin
        prdata_r[7:0] <= high_capture_b_r;
      end
    end
  end

  // Match flags: a hardware set in the same cycle as a clearing write wins
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr && hit_ctl) begin
      ctl_nxt = pwdata[7:0];
    end
    if (high_match) begin
      ctl_nxt[`CTL_HIGH_FLAG_BIT] = 1'b1;
    end
    if (low_match) begin
      ctl_nxt[`CTL_LOW_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= `RST_TIMER_CONTROL;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_match_r  <= `RST_PRESCALER_MATCH;
      low_match_value_r  <= `RST_MATCH_VALUE;
      high_match_value_r <= `RST_MATCH_VALUE;
    end else if (wr) begin
      if (hit_prr) begin
        prescaler_match_r <= pwdata[7:0];
      end
      if (hit_lmv) begin
        low_match_value_r <= pwdata[7:0];
      end
      if (hit_hmv) begin
        high_match_value_r <= pwdata[7:0];
      end
    end
  end

  // Prescaler: period of match value plus one cycle clocks
  assign pre_match      = (pre_cnt_r == prescaler_match_r);
  assign prescaler_tick = pre_match;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 8'h00;
    end else if (pre_match || (wr && hit_prr)) begin
      pre_cnt_r <= 8'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  // Low byte clock: prescaler or external event pulses
  assign low_inc = ctl_r.low_external_clock_select ? event_count_input : pre_match;

  // Joined counter needs both run bits so the two halves never drift apart
  assign joined_run   = ctl_r.low_run & ctl_r.high_run;
  assign joined_match = joined_run & low_inc &
                        ({high_counter_r, low_counter_r} == {high_buf_r, low_buf_r});

  always_comb begin
    if (ctl_r.joined_length_select) begin
      low_match  = joined_match;
      high_match = joined_match;
      low_step   = joined_run & low_inc;
      high_step  = joined_run & low_inc & (low_counter_r == 8'hFF);
    end else begin
      low_match  = ctl_r.low_run & low_inc & (low_counter_r == low_buf_r);
      high_match = ctl_r.high_run & pre_match & (high_counter_r == high_buf_r);
      low_step   = ctl_r.low_run & low_inc;
      high_step  = ctl_r.high_run & pre_match;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_counter_r <= `RST_COUNT;
    end else if (!ctl_r.low_run) begin
      low_counter_r <= 8'h00;
    end else if (low_match) begin
      low_counter_r <= 8'h00;
    end else if (low_step) begin
      low_counter_r <= low_counter_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_counter_r <= `RST_COUNT;
    end else if (!ctl_r.high_run) begin
      high_counter_r <= 8'h00;
    end else if (high_match) begin
      high_counter_r <= 8'h00;
    end else if (high_step) begin
      high_counter_r <= high_counter_r + 8'h01;
    end
  end

  // Compare buffers: a new match value takes effect at a period boundary, or at once while the run bit is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_buf_r  <= `RST_MATCH_VALUE;
      high_buf_r <= `RST_MATCH_VALUE;
    end else begin
      if (!ctl_r.low_run || low_match) begin
        low_buf_r <= low_match_value_r;
      end
      if (!ctl_r.high_run || high_match) begin
        high_buf_r <= high_match_value_r;
      end
    end
  end

  // Capture routing; in joined modes the high sources capture both bytes
  always_comb begin
    if (ctl_r.joined_length_select) begin
      cap_la_ev = capture_pulses.high_capture_input;
      cap_ha_ev = capture_pulses.high_capture_input;
      cap_lb_ev = capture_pulses.high_capture_input_b;
      cap_hb_ev = capture_pulses.high_capture_input_b;
    end else begin
      cap_la_ev = capture_pulses.low_capture_input;
      cap_ha_ev = capture_pulses.high_capture_input;
      cap_lb_ev = capture_pulses.low_capture_input_b;
      cap_hb_ev = capture_pulses.high_capture_input_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_capture_a_r  <= `RST_CAPTURE;
      high_capture_a_r <= `RST_CAPTURE;
      low_capture_b_r  <= `RST_CAPTURE;
      high_capture_b_r <= `RST_CAPTURE;
    end else begin
      if (cap_la_ev) begin
        low_capture_a_r <= low_counter_r;
      end
      if (cap_ha_ev) begin
        high_capture_a_r <= high_counter_r;
      end
      if (cap_lb_ev) begin
        low_capture_b_r <= low_counter_r;
      end
      if (cap_hb_ev) begin
        high_capture_b_r <= high_counter_r;
      end
    end
  end

  // Request stays high until software clears the flag or the enable
  assign low_irq  = ctl_r.low_match_flag & ctl_r.low_irq_enable;
  assign high_irq = ctl_r.high_match_flag & ctl_r.high_irq_enable;

endmodule

`default_nettype wire

// File: dual_byte_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
module dual_byte_timer_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        prescaler_tick,
  input wire logic        low_irq,
  input wire logic        high_irq
);
  logic acc;
  logic setup;
  logic ctl_hit;
  assign acc = psel && penable;
  assign setup = psel && !penable;
  assign ctl_hit = acc && pwrite && paddr == 32'h0003F840;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence pre_wr3;
    setup && paddr == 32'h0003F844 ##1 acc && pwrite && pwdata[7:0] == 8'h03;
  endsequence
  sequence gap3_tick;
    !prescaler_tick [*3] ##1 prescaler_tick;
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  chk_err_hole: assert property (acc && paddr == 32'h0003F860 |-> pslverr)
    else $error("unmapped access not refused");
  chk_tick_restart: assert property (pre_wr3 |=> gap3_tick)
    else $error("prescaler restart wrong");
  chk_low_masked: assert property (ctl_hit && !pwdata[0] |=> !low_irq)
    else $error("low irq while disabled");
  chk_high_masked: assert property (ctl_hit && !pwdata[2] |=> !high_irq)
    else $error("high irq while disabled");
  chk_flag_sticky: assert property ($fell(low_irq) || $fell(high_irq) |-> $past(ctl_hit))
    else $error("flag cleared by hardware");
  chk_rdata_hold: assert property ($changed(prdata) |-> $past(setup))
    else $error("prdata moved outside setup");
  chk_rdata_upper: assert property (prdata[31:8] == 24'h000000)
    else $error("prdata upper bits set");
endmodule
bind dual_byte_timer dual_byte_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .prescaler_tick(prescaler_tick), .low_irq(low_irq), .high_irq(high_irq));
`default_nettype wire

// File: event_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module event_pins_model
  import dual_byte_timer_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic [4:0]     req,
  input  wire logic [7:0]     gap,
  output var  logic           event_count_input,
  output var  capture_pulses_t capture_pulses
);
  logic [7:0] cnt_r;
  // Requests are registered straight through with no edge detection, so a held request gives a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      event_count_input <= 1'b0;
      capture_pulses <= '0;
    end else begin
      cnt_r <= (cnt_r + 8'h01 >= gap) ? 8'h00 : cnt_r + 8'h01;
      event_count_input <= req[4] || (gap != 8'h00 && cnt_r == 8'h00);
      capture_pulses <= req[3:0];
    end
  end
endmodule
`default_nettype wire

// File: dual_byte_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_byte_timer_tb
  import dual_byte_timer_pkg::*;
;
  typedef struct packed {logic w; logic [15:0] i; logic [7:0] d; logic [7:0] x;} row_t;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, ev, tick, low_irq, high_irq, e;
  logic [31:0]     paddr, pwdata, prdata;
  capture_pulses_t cap;
  logic [4:0]      req;
  logic [7:0]      gap, q;
  int              err_count, cmp_count, cyc, t0, p;
  row_t rows [15] = '{'{0,16'hFE10,0,0}, '{0,16'hFE11,0,0}, '{0,16'hFE12,0,0}, '{0,16'hFE13,0,0},
    '{0,16'hFE14,0,0}, '{0,16'hFE15,0,0}, '{0,16'hFE16,0,0}, '{0,16'hFE17,0,0}, '{0,16'hFE1E,0,0},
    '{0,16'hFE1F,0,0}, '{1,16'hFE11,3,3}, '{1,16'hFE14,8'hA5,8'hA5}, '{1,16'hFE15,8'h3C,8'h3C},
    '{1,16'hFE12,8'hFF,0}, '{1,16'hFE17,8'hFF,0}};
  dual_byte_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_count_input(ev), .capture_pulses(cap), .prescaler_tick(tick), .low_irq(low_irq), .high_irq(high_irq));
  event_pins_model pins (.pclk(pclk), .presetn(presetn), .req(req), .gap(gap),
    .event_count_input(ev), .capture_pulses(cap));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  // Ends one edge after release so a following call never reassigns psel in the same step
  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0000, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] x);
    apb(1'b0, i, 8'h00);
    chk($sformatf("reg %h", i), q, x);
  endtask
  task automatic pulse(input logic [4:0] v);
    req <= v;
    @(posedge pclk);
    req <= 5'h00;
    @(posedge pclk);
  endtask
  // Rewriting the control word clears the flags between the two timed requests
  task automatic measure(input logic [7:0] c, input int x);
    apb(1'b1, 16'hFE10, c);
    for (int k = 0; k < 2; k++) begin
      while ((low_irq | high_irq) !== 1'b1) @(posedge pclk);
      p = cyc - t0;
      t0 = cyc;
      apb(1'b1, 16'hFE10, c);
    end
    chk("period", p, x);
    apb(1'b1, 16'hFE10, 8'h00);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req, gap, presetn} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[r]) begin
      apb(rows[r].w, rows[r].i, rows[r].d);
      if (rows[r].w) apb(1'b0, rows[r].i, 8'h00);
      chk("row", q, rows[r].x);
      chk("row err", e, 1'b0);
    end
    apb(1'b0, 16'hFE18, 8'h00);
    chk("unmapped", e, 1'b1);
    apb(1'b1, 16'hFE11, 8'h01);
    apb(1'b1, 16'hFE14, 8'h02);
    apb(1'b1, 16'hFE15, 8'h01);
    measure(8'hC1, 6);
    measure(8'hC4, 4);
    gap <= 8'h03;
    measure(8'hD1, 9);
    apb(1'b1, 16'hFE14, 8'h00);
    gap <= 8'h01;
    measure(8'hF1, 257);
    gap <= 8'h00;
    measure(8'hE1, 514);
    apb(1'b1, 16'hFE14, 8'hFF);
    apb(1'b1, 16'hFE15, 8'hFF);
    apb(1'b1, 16'hFE10, 8'hF0);
    repeat (259) pulse(5'h10);
    pulse(5'h03);
    rd(16'hFE12, 8'h03);
    rd(16'hFE13, 8'h01);
    rd(16'hFE16, 8'h03);
    rd(16'hFE17, 8'h01);
    rd(16'hFE1E, 8'h03);
    rd(16'hFE1F, 8'h01);
    apb(1'b1, 16'hFE10, 8'h00);
    apb(1'b1, 16'hFE10, 8'h50);
    repeat (5) pulse(5'h10);
    pulse(5'h0F);
    rd(16'hFE16, 8'h05);
    rd(16'hFE1E, 8'h05);
    rd(16'hFE17, 8'h00);
    rd(16'hFE1F, 8'h00);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(16'hFE10, 8'h00);
    rd(16'hFE12, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
